// ### bench/fcdr_sep_model.sv
`timescale 1ns/1ps
module fcdr_sep_model (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Search request and its outcome
    input wire logic id_search,
    input wire logic fail,
    input wire logic [3:0] lat,
    output logic id_found,
    output logic id_fail
);
    int wait_cnt;
    // One outcome per search; a late search drop gets no second pulse
    always @(posedge clock) begin
        id_found <= 1'b0;
        id_fail <= 1'b0;
        if (!reset_n || !id_search) begin
            wait_cnt <= 0;
        end else begin
            wait_cnt <= wait_cnt + 1;
            if (wait_cnt == 2 + int'(lat)) begin
                id_found <= !fail;
                id_fail <= fail;
            end
        end
    end
endmodule // fcdr_sep_model

// ### bench/fcdr_top_chk.sv
`timescale 1ns/1ps
module fcdr_top_chk
    import fcdr_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Decode and state
    input wire logic [7:0] cmd_byte,
    input wire logic cmd_strobe,
    input wire logic ext_cmd_claim,
    input wire logic id_search,
    input wire logic [1:0] id_drive,
    input wire logic id_head,
    input wire logic id_found,
    input wire logic standby,
    input wire logic lock_state,
    input wire logic [3:0] perp_drive_flags
);
    import fcdr_pkg::*;
    logic known;
    assign known = (cmd_byte & OP_READ_ID_MASK) == OP_READ_ID || cmd_byte == OP_DUMP
        || cmd_byte == OP_PERP || (cmd_byte & OP_LOCK_MASK) == OP_LOCK;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    sequence lock_op;
        cmd_strobe && !ext_cmd_claim && (cmd_byte & OP_LOCK_MASK) == OP_LOCK;
    endsequence
    sequence bad_op;
        cmd_strobe && !ext_cmd_claim && !known;
    endsequence
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    strobe_src_a: assert property (cmd_strobe |-> $past(hsel && htrans[1] && hwrite)
        && $past(haddr[7:0]) == ADDR_DATA && cmd_byte == hwdata[7:0])
        else $error("opcode strobe without data write");
    lock_set_a: assert property (lock_op |=> lock_state == $past(cmd_byte[LOCK_BIT]))
        else $error("lock not taken from opcode");
    lock_hold_a: assert property (!$stable(lock_state) |-> $past(cmd_strobe && !ext_cmd_claim
        && (cmd_byte & OP_LOCK_MASK) == OP_LOCK)) else $error("lock moved without opcode");
    bad_op_a: assert property (bad_op |=> standby)
        else $error("no standby after unknown opcode");
    claim_clear_a: assert property (cmd_strobe && ext_cmd_claim |=> !standby)
        else $error("standby kept on claimed opcode");
    perp_ow_a: assert property (!$stable(perp_drive_flags) |-> $past(hwdata[OVERWRITE_BIT])
        && perp_drive_flags == $past(hwdata[5:2])) else $error("flags moved without enable");
    id_start_a: assert property ($rose(id_search) |-> id_drive == $past(hwdata[1:0])
        && id_head == $past(hwdata[2])) else $error("search select wrong");
    id_end_a: assert property (id_search && id_found |=> !id_search)
        else $error("search kept after id found");
endmodule // fcdr_top_chk
bind fcdr_top fcdr_top_chk u_chk (.clock(clock), .reset_n(reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hreadyout(hreadyout),
    .hresp(hresp), .cmd_byte(cmd_byte), .cmd_strobe(cmd_strobe), .ext_cmd_claim(ext_cmd_claim),
    .id_search(id_search), .id_drive(id_drive), .id_head(id_head), .id_found(id_found),
    .standby(standby), .lock_state(lock_state), .perp_drive_flags(perp_drive_flags));

// ### bench/test_floppy_cmd_dump_readid_perp.sv
`timescale 1ns/1ps
module test_floppy_cmd_dump_readid_perp;
    import fcdr_pkg::*;
    logic clock = 0, reset_n = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, last;
    logic [1:0] htrans = 0, drv;
    logic [3:0][7:0] cyl4 = 0;
    logic [3:0] stp = 0, unl = 0, thr = 0, perp, lat = 0, x_perp;
    logic [6:0] hld = 0;
    logic ndma = 0, fmt = 0, rw = 0, eis = 0, efifo = 0, poll = 0, claim = 0, fail = 0;
    logic search, head, dd, found, idf, stby, lock, gap, wg, x_lock, x_gap, x_wg, dp_rd = 0;
    logic [7:0] scnt = 0, fsn = 0, pre = 0, c = 0, h = 0, r = 0, n = 0, d;
    logic [8:0] q[$];
    int errors = 0, checked = 0;
    always #5 clock = ~clock;
    fcdr_top DUT (.clock(clock), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .present_cylinder(cyl4),
        .step_rate(stp), .head_unload_time(unl), .head_load_time(hld), .non_dma_flag(ndma),
        .sector_count(scnt), .final_sector_number(fsn), .last_was_format(fmt),
        .last_was_rw(rw), .cfg_eis(eis), .cfg_efifo(efifo), .cfg_poll(poll),
        .cfg_fifothr(thr), .cfg_pretrk(pre), .cmd_byte(), .cmd_strobe(),
        .ext_cmd_claim(claim), .id_search(search), .id_drive(drv), .id_head(head),
        .id_double_density(dd), .id_found(found), .id_fail(idf), .id_cyl(c), .id_head_no(h),
        .id_rec(r), .id_size(n), .standby(stby), .lock_state(lock), .perp_drive_flags(perp),
        .gap_setting(gap), .write_gate_control(wg));
    fcdr_sep_model SEP (.clock(clock), .reset_n(reset_n), .id_search(search), .fail(fail),
        .lat(lat), .id_found(found), .id_fail(idf));
    task check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task conclude;
        if (errors == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Result bytes are judged here, one queued note per data-phase read
    always @(posedge clock) begin
        if (dp_rd && q.size() > 0) begin
            if (q[0][8]) check(hrdata[7:0], q[0][7:0]);
            void'(q.pop_front());
        end
        dp_rd <= hsel && htrans[1] && !hwrite;
    end
    task xfer(input logic [7:0] a, input logic w, input logic [7:0] wd);
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
        do @(posedge clock); while (hreadyout !== 1'b1);
        last = hrdata;
    endtask
    task rd(input logic care, input logic [7:0] e);
        q.push_back({care, e});
        xfer(ADDR_DATA, 1'b0, 8'h00);
    endtask
    task wait_res;
        for (int i = 0; i < 60 && last[2] !== 1'b1; i++) rd_status();
        check({7'h0, last[2]}, 8'h01);
    endtask
    task rd_status;
        q.push_back(9'h0);
        xfer(ADDR_STATUS, 1'b0, 8'h00);
    endtask
    task rnd;
        @(posedge clock);
        cyl4 <= {$urandom};
        {stp, unl, hld, ndma, scnt, fsn, pre} <= 40'({$urandom, $urandom});
        {eis, efifo, poll, thr} <= 7'($urandom);
        {c, h, r, n} <= $urandom;
        lat <= 4'($urandom);
    endtask
    // Byte 6 is picked when the result is filled after the opcode write, so inputs changed just before the call count
    task dump(input logic want_final);
        last = 0;
        xfer(ADDR_DATA, 1'b1, OP_DUMP);
        wait_res();
        for (int i = 0; i < 4; i++) rd(1'b1, cyl4[i]);
        rd(1'b1, {stp, unl});
        rd(1'b1, {hld, ndma});
        rd(1'b1, want_final ? fsn : scnt);
        rd(1'b1, {x_lock, 1'b0, x_perp, x_gap, x_wg});
        rd(1'b1, {1'b0, eis, efifo, poll, thr});
        rd(1'b1, pre);
    endtask
    task cmd_res(input logic [7:0] op, input logic [7:0] e);
        last = 0;
        xfer(ADDR_DATA, 1'b1, op);
        wait_res();
        rd(1'b1, e);
    endtask
    initial begin
        {x_lock, x_perp, x_gap, x_wg} = 7'h0;
        void'($urandom(10702));
        repeat (16) @(posedge clock);
        reset_n <= 1'b1;
        rnd();
        fmt <= 1'b1;
        rw <= 1'b1;
        dump(1'b0);
        fmt <= 1'b0;
        rnd();
        dump(1'b1);
        for (int k = 0; k < 4; k++) begin
            d = {k[0] == 1'b0, 7'($urandom)};
            xfer(ADDR_DATA, 1'b1, OP_PERP);
            xfer(ADDR_DATA, 1'b1, d);
            if (d[OVERWRITE_BIT]) x_perp = d[5:2];
            x_gap = d[GAP_BIT];
            x_wg = d[WRITE_GATE_BIT];
            @(posedge clock);
            check({perp, 2'b0, gap, wg}, {x_perp, 2'b0, x_gap, x_wg});
        end
        for (int k = 0; k < 2; k++) begin
            x_lock = k[0] == 1'b0;
            cmd_res({x_lock, OP_LOCK[6:0]}, {3'h0, x_lock, 4'h0});
        end
        dump(1'b1);
        for (int f = 0; f < 2; f++) begin
            rnd();
            fail <= f[0];
            d = 8'($urandom) & 8'h07;
            xfer(ADDR_DATA, 1'b1, OP_READ_ID | {f[0] == 1'b0, 6'h0});
            xfer(ADDR_DATA, 1'b1, d);
            last = 0;
            @(posedge clock);
            #1 check({drv, head, dd}, {d[1:0], d[2], f[0] == 1'b0});
            wait_res();
            rd(1'b1, {f[0] ? IC_ABNORMAL : 2'b00, 3'h0, d[2:0]});
            rd(1'b1, f[0] ? ST1_NO_MARK : 8'h00);
            rd(1'b1, 8'h00);
            rd(!f[0], c);
            rd(!f[0], h);
            rd(!f[0], r);
            rd(!f[0], n);
        end
        cmd_res(8'hff, STATUS_ZERO_INVALID);
        check({7'h0, stby}, 8'h01);
        claim <= 1'b1;
        xfer(ADDR_DATA, 1'b1, 8'h07);
        claim <= 1'b0;
        @(posedge clock);
        check({7'h0, stby}, 8'h00);
        cmd_res(8'h94, 8'h10);
        reset_n <= 1'b0;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        {x_lock, x_perp, x_gap, x_wg} = 7'h0;
        #1 check({lock, perp, gap, wg}, 8'h00);
        dump(1'b1);
        conclude();
    end
    initial begin
        #400000;
        errors++;
        conclude();
    end
endmodule // test_floppy_cmd_dump_readid_perp

// ### rtl/fcdr_mem_if.sv
`timescale 1ns/1ps
interface fcdr_mem_if;
    logic wr_en;
    logic [3:0] wr_addr;
    logic [7:0] wr_data;
    logic [3:0] rd_addr;
    logic [7:0] rd_data;
    modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// ### rtl/fcdr_pkg.sv
package fcdr_pkg;
    // Bus map, byte addresses
    localparam logic [7:0] ADDR_DATA = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    // Opcodes and masks
    localparam logic [7:0] OP_DUMP = 8'h0e;
    localparam logic [7:0] OP_READ_ID = 8'h0a;
    localparam logic [7:0] OP_READ_ID_MASK = 8'hbf;
    localparam logic [7:0] OP_PERP = 8'h12;
    localparam logic [7:0] OP_LOCK = 8'h14;
    localparam logic [7:0] OP_LOCK_MASK = 8'h7f;
    // Field positions
    localparam int DENSITY_BIT = 6;
    localparam int LOCK_BIT = 7;
    localparam int LOCK_RES_BIT = 4;
    localparam int OVERWRITE_BIT = 7;
    localparam int PERP_LSB = 2;
    localparam int GAP_BIT = 1;
    localparam int WRITE_GATE_BIT = 0;
    // Result values and lengths
    localparam logic [7:0] STATUS_ZERO_INVALID = 8'h80;
    localparam logic [1:0] IC_ABNORMAL = 2'b01;
    localparam logic [7:0] ST1_NO_MARK = 8'h01;
    localparam logic [3:0] DUMP_LEN = 4'ha;
    localparam logic [3:0] READ_ID_LEN = 4'h7;
    localparam logic [3:0] ONE_BYTE = 4'h1;
    // Reset values
    localparam logic [3:0] PERP_RESET = 4'h0;
    localparam logic LOCK_RESET = 1'b0;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_PARAM = 3'b001,
        S_EXEC = 3'b010,
        S_FILL = 3'b011,
        S_RESULT = 3'b100
    } fcdr_state_type;

    typedef enum logic [2:0] {
        K_DUMP = 3'b000,
        K_READ_ID = 3'b001,
        K_PERP = 3'b010,
        K_LOCK = 3'b011,
        K_INVALID = 3'b100
    } fcdr_kind_type;
endpackage

// ### rtl/fcdr_result_mem.sv
`timescale 1ns/1ps
module fcdr_result_mem (
    // Clock
    input wire logic clock,
    // Ports
    fcdr_mem_if.mem port
);
    logic [7:0] store_ff [0:15];
    logic [7:0] rd_ff;

    // Storage has no reset; a data read outside S_RESULT can return an entry never written
    always_ff @(posedge clock) begin
        if (port.wr_en) begin
            store_ff[port.wr_addr] <= port.wr_data;
        end
        rd_ff <= store_ff[port.rd_addr];
    end

    assign port.rd_data = rd_ff;
endmodule // fcdr_result_mem

// ### rtl/fcdr_top.sv
// The implementer's own choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
module fcdr_top (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Controller context kept by other command logic
    input wire logic [3:0][7:0] present_cylinder,
    input wire logic [3:0] step_rate,
    input wire logic [3:0] head_unload_time,
    input wire logic [6:0] head_load_time,
    input wire logic non_dma_flag,
    input wire logic [7:0] sector_count,
    input wire logic [7:0] final_sector_number,
    input wire logic last_was_format,
    input wire logic last_was_rw,
    input wire logic cfg_eis,
    input wire logic cfg_efifo,
    input wire logic cfg_poll,
    input wire logic [3:0] cfg_fifothr,
    input wire logic [7:0] cfg_pretrk,
    // Opcode offered to the other command decoders
    output logic [7:0] cmd_byte,
    output logic cmd_strobe,
    input wire logic ext_cmd_claim,
    // ID search on the data separator
    output logic id_search,
    output logic [1:0] id_drive,
    output logic id_head,
    output logic id_double_density,
    input wire logic id_found,
    input wire logic id_fail,
    input wire logic [7:0] id_cyl,
    input wire logic [7:0] id_head_no,
    input wire logic [7:0] id_rec,
    input wire logic [7:0] id_size,
    // Mode state
    output logic standby,
    output logic lock_state,
    output logic [3:0] perp_drive_flags,
    output logic gap_setting,
    output logic write_gate_control
);
    import fcdr_pkg::*;

    typedef struct packed {
        fcdr_state_type state;
        fcdr_kind_type kind;
        logic [2:0] sel;
        logic dd_flag;
        logic [3:0] idx;
        logic [3:0] nres;
        logic [3:0] rptr;
        logic standby;
        logic lock;
        logic [3:0] perp;
        logic gap;
        logic wr_gate;
        logic [7:0] status_zero;
        logic [7:0] st1;
        logic [7:0] idc;
        logic [7:0] idh;
        logic [7:0] idr;
        logic [7:0] idn;
        logic ap_wr;
        logic ap_rd_data;
        logic ap_rd_stat;
    } fcdr_regs_type;

    fcdr_regs_type r_ff;
    fcdr_regs_type nxt_r;
    fcdr_mem_if mem_port ();

    function automatic fcdr_kind_type op_kind(input logic [7:0] op);
        if (op == OP_DUMP) begin
            return K_DUMP;
        end else if ((op & OP_READ_ID_MASK) == OP_READ_ID) begin
            return K_READ_ID;
        end else if (op == OP_PERP) begin
            return K_PERP;
        end else if ((op & OP_LOCK_MASK) == OP_LOCK) begin
            return K_LOCK;
        end else begin
            return K_INVALID;
        end
    endfunction

    function automatic logic [3:0] res_len(input fcdr_kind_type k);
        case (k)
            K_DUMP: return DUMP_LEN;
            K_READ_ID: return READ_ID_LEN;
            default: return ONE_BYTE;
        endcase
    endfunction

    fcdr_result_mem u_mem (
        .clock(clock),
        .port(mem_port.mem)
    );

    logic addr_ok;
    logic data_wr;
    logic data_rd;
    logic [7:0] wbyte;
    logic [7:0] fill_byte;
    logic [7:0] count_byte;

    assign addr_ok = hsel && hready && htrans[1];
    assign data_wr = r_ff.ap_wr;
    assign wbyte = hwdata[7:0];
    // Opcode goes out raw so the other decoders can claim it in the same cycle
    assign cmd_byte = wbyte;
    assign cmd_strobe = data_wr && (r_ff.state == S_IDLE);
    // A read pops in its address phase; the memory then delivers the old slot
    assign data_rd = addr_ok && !hwrite && (haddr[7:0] == ADDR_DATA)
        && (r_ff.state == S_RESULT);

    // Dump byte 6 choice
    always_comb begin
        if (last_was_format) begin
            count_byte = sector_count;
        end else if (last_was_rw) begin
            count_byte = final_sector_number;
        end else begin
            count_byte = sector_count;
        end
    end

    always_comb begin
        fill_byte = 8'h00;
        case (r_ff.kind)
            K_DUMP: begin
                case (r_ff.idx)
                    4'h0: fill_byte = present_cylinder[0];
                    4'h1: fill_byte = present_cylinder[1];
                    4'h2: fill_byte = present_cylinder[2];
                    4'h3: fill_byte = present_cylinder[3];
                    4'h4: fill_byte = {step_rate, head_unload_time};
                    4'h5: fill_byte = {head_load_time, non_dma_flag};
                    4'h6: fill_byte = count_byte;
                    4'h7: fill_byte = {r_ff.lock, 1'b0, r_ff.perp, r_ff.gap, r_ff.wr_gate};
                    4'h8: fill_byte = {1'b0, cfg_eis, cfg_efifo, cfg_poll, cfg_fifothr};
                    default: fill_byte = cfg_pretrk;
                endcase
            end
            K_READ_ID: begin
                case (r_ff.idx)
                    4'h0: fill_byte = r_ff.status_zero;
                    4'h1: fill_byte = r_ff.st1;
                    4'h2: fill_byte = 8'h00;
                    4'h3: fill_byte = r_ff.idc;
                    4'h4: fill_byte = r_ff.idh;
                    4'h5: fill_byte = r_ff.idr;
                    default: fill_byte = r_ff.idn;
                endcase
            end
            K_LOCK: begin
                fill_byte = 8'h00;
                fill_byte[LOCK_RES_BIT] = r_ff.lock;
            end
            default: fill_byte = STATUS_ZERO_INVALID;
        endcase
    end

    assign mem_port.wr_en = (r_ff.state == S_FILL);
    assign mem_port.wr_addr = r_ff.idx;
    assign mem_port.wr_data = fill_byte;
    assign mem_port.rd_addr = r_ff.rptr;

    always_comb begin
        nxt_r = r_ff;
        // Bus address phase capture
        if (hready) begin
            nxt_r.ap_wr = addr_ok && hwrite && (haddr[7:0] == ADDR_DATA);
            nxt_r.ap_rd_data = addr_ok && !hwrite && (haddr[7:0] == ADDR_DATA);
            nxt_r.ap_rd_stat = addr_ok && !hwrite && (haddr[7:0] == ADDR_STATUS);
        end
        case (r_ff.state)
            S_IDLE: begin
                if (data_wr && !ext_cmd_claim) begin
                    nxt_r.kind = op_kind(wbyte);
                    nxt_r.idx = 4'h0;
                    nxt_r.nres = res_len(op_kind(wbyte));
                    nxt_r.standby = 1'b0;
                    case (op_kind(wbyte))
                        K_READ_ID: begin
                            nxt_r.dd_flag = wbyte[DENSITY_BIT];
                            nxt_r.state = S_PARAM;
                        end
                        K_PERP: nxt_r.state = S_PARAM;
                        K_LOCK: begin
                            nxt_r.lock = wbyte[LOCK_BIT];
                            nxt_r.state = S_FILL;
                        end
                        K_INVALID: begin
                            nxt_r.standby = 1'b1;
                            nxt_r.state = S_FILL;
                        end
                        default: nxt_r.state = S_FILL;
                    endcase
                end else if (data_wr) begin
                    nxt_r.standby = 1'b0;
                end
            end
            S_PARAM: begin
                if (data_wr) begin
                    if (r_ff.kind == K_READ_ID) begin
                        nxt_r.sel = wbyte[2:0];
                        nxt_r.state = S_EXEC;
                    end else begin
                        if (wbyte[OVERWRITE_BIT]) begin
                            nxt_r.perp = wbyte[PERP_LSB +: 4];
                        end
                        nxt_r.gap = wbyte[GAP_BIT];
                        nxt_r.wr_gate = wbyte[WRITE_GATE_BIT];
                        nxt_r.state = S_IDLE;
                    end
                end
            end
            S_EXEC: begin
                // Success wins if the separator reports both at once
                if (id_found) begin
                    nxt_r.status_zero = {5'b00000, r_ff.sel};
                    nxt_r.st1 = 8'h00;
                    nxt_r.idc = id_cyl;
                    nxt_r.idh = id_head_no;
                    nxt_r.idr = id_rec;
                    nxt_r.idn = id_size;
                    nxt_r.state = S_FILL;
                end else if (id_fail) begin
                    nxt_r.status_zero = {IC_ABNORMAL, 3'b000, r_ff.sel};
                    nxt_r.st1 = ST1_NO_MARK;
                    nxt_r.idc = id_cyl;
                    nxt_r.idh = id_head_no;
                    nxt_r.idr = id_rec;
                    nxt_r.idn = id_size;
                    nxt_r.state = S_FILL;
                end
            end
            S_FILL: begin
                if (r_ff.idx == r_ff.nres - 4'h1) begin
                    nxt_r.rptr = 4'h0;
                    nxt_r.state = S_RESULT;
                end else begin
                    nxt_r.idx = r_ff.idx + 4'h1;
                end
            end
            S_RESULT: begin
                // Writes during the result phase are dropped
                if (data_rd) begin
                    nxt_r.rptr = r_ff.rptr + 4'h1;
                    if (r_ff.rptr == r_ff.nres - 4'h1) begin
                        nxt_r.state = S_IDLE;
                    end
                end
            end
            default: nxt_r.state = S_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            r_ff <= '0;
            r_ff.state <= S_IDLE;
            r_ff.kind <= K_INVALID;
            r_ff.lock <= LOCK_RESET;
            r_ff.perp <= PERP_RESET;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // Data phase answers are zero-wait; status shows the block's progress
    always_comb begin
        hrdata = 32'h0000_0000;
        if (r_ff.ap_rd_data) begin
            hrdata = {24'h000000, mem_port.rd_data};
        end else if (r_ff.ap_rd_stat) begin
            hrdata = {16'h0000, 4'(r_ff.nres - r_ff.rptr), 1'b0, r_ff.state,
                r_ff.standby, r_ff.lock, (r_ff.state == S_EXEC),
                (r_ff.state == S_PARAM), (r_ff.state == S_IDLE),
                (r_ff.state == S_RESULT), 2'b00};
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign id_search = (r_ff.state == S_EXEC);
    // Drive bits feed the ID search and result byte 0, never a select pin
    assign id_drive = r_ff.sel[1:0];
    assign id_head = r_ff.sel[2];
    assign id_double_density = r_ff.dd_flag;
    assign standby = r_ff.standby;
    assign lock_state = r_ff.lock;
    assign perp_drive_flags = r_ff.perp;
    assign gap_setting = r_ff.gap;
    assign write_gate_control = r_ff.wr_gate;
endmodule // fcdr_top
